// ### rtl/source_link_end.sv
/*
 * Source end of the control wire: supply wait, wake sequence,
 * discovery pulses, connect, termination sensing and disconnect.
 * Assumes same-clock link-layer inputs; wire, sense and supply are async.
 */
// Operation
// - Wake short high and low phases 20 ms
// - Wake long middle low phase 60 ms
// - First discovery pulse 100..1000 ms after wake
// - Sink applies discovery pull-down within 100 ms
// - Wait supply 100 ms, contention at 1000 ms
// - Discovery high and float each 100 us
// - Sink accepts phases 70 to 130 us
// - Sink rejects phases up to 40 or beyond 200
// - High during float: pull-up on within 240 us
// - Five valid pulses: sink connects within 40 us
// - Try at least six, give up at twenty
// - Disconnect floats wire at least 50 ms
// - Sink enables termination within 200 ms
// - Termination change: ignore under 100, act past 200
// - No termination after 300..500 ms: give up; code floats the wire at 400 ms, then returns to S_IDLE and can wake again
// - Arbitrate after 500 us or peer arbitration
// - Sink disconnects on low beyond 150..240 us
// - Sink sets capability-ready within 500 ms
// - Dongle power-on raises capability-changed within 500 ms
// - Source reads capabilities within 500 ms of event
// - Disconnect: video off, wire high-impedance within 150 ms
// - Sink restores pull-down, drops termination within 5 ms
`timescale 1ns/100ps
`default_nettype none

module source_link_end
	import wire_link_pkg::*;
#(
	parameter int US_PER_MS_P = US_PER_MS
) (
	input  wire logic       clk_sys_i,
	input  wire logic       srst_i,
	control_wire_if.source  bus,
	input  wire logic       supply_ok_i,
	input  wire logic       peer_arb_i,
	input  wire logic       cap_event_i,
	input  wire logic       disconnect_i,
	output logic            connected_o,
	output logic            video_en_o,
	output logic            arb_ok_o,
	output logic            cap_read_o,
	output logic            no_sink_o,
	output logic            contention_o
);
	// ****************************************
	// Timing counts in microsecond ticks
	// ****************************************
	localparam logic [19:0] C_WAKE_S   = 20'(WAKE_SHORT_MS * US_PER_MS_P);
	localparam logic [19:0] C_WAKE_L   = 20'(WAKE_LONG_MS * US_PER_MS_P);
	localparam logic [19:0] C_W2D      = 20'(WAKE_TO_DISC_MS * US_PER_MS_P);
	localparam logic [19:0] C_SUP_MIN  = 20'(SUPPLY_MIN_MS * US_PER_MS_P);
	localparam logic [19:0] C_SUP_MAX  = 20'(SUPPLY_MAX_MS * US_PER_MS_P);
	localparam logic [19:0] C_FLOAT    = 20'(SRC_FLOAT_MS * US_PER_MS_P);
	localparam logic [19:0] C_DEGLITCH = 20'(DEGLITCH_MS * US_PER_MS_P);
	localparam logic [19:0] C_TERM_CHK = 20'(TERM_CHECK_MS * US_PER_MS_P);
	localparam logic [19:0] C_PULSE    = 20'(PULSE_US);
	localparam logic [19:0] C_GUARD    = 20'(FLOAT_GUARD_US);
	localparam logic [19:0] C_ARB      = 20'(ARB_HOLD_US);

	// ****************************************
	// State
	// ****************************************
	typedef enum logic [9:0] {
		S_IDLE    = 10'h001,
		S_SUPPLY  = 10'h002,
		S_WAKE    = 10'h004,
		S_W2D     = 10'h008,
		S_DISC_HI = 10'h010,
		S_DISC_FL = 10'h020,
		S_CONN    = 10'h040,
		S_FLOAT   = 10'h080,
		S_NO_SINK = 10'h100,
		S_CONTEND = 10'h200
	} src_state_e;

	typedef struct packed {
		src_state_e  st;
		logic [19:0] tmr;
		logic [19:0] dg;
		logic [2:0]  phase;
		logic [4:0]  pulses;
		logic [2:0]  w_s;
		logic        w;
		logic [2:0]  t_s;
		logic        t;
		logic [2:0]  p_s;
		logic        p;
		logic        term_seen;
		logic        drv;
		logic        oe_n;
		logic        pu_disc;
		logic        pu_on;
		logic        video_en;
		logic        arb_ok;
		logic        cap_rd;
		logic        no_sink;
		logic        contend;
		logic        conn;
	} src_q_s;

	localparam src_q_s Q_RST = '{st: S_IDLE, w_s: 3'h7, w: 1'b1, oe_n: 1'b1,
		default: '0};

	src_q_s q;
	src_q_s next_q;
	logic   tick;
	logic   restart;

	tick_divider #(.DIV(CYC_PER_US)) u_div (
		.clk_sys_i (clk_sys_i),
		.srst_i    (srst_i),
		.tick_o    (tick)
	);

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		next_q = q;
		restart = 1'b0;
		next_q.w_s = {q.w_s[1:0], bus.control_wire};
		next_q.t_s = {q.t_s[1:0], bus.receiver_termination_sense};
		next_q.p_s = {q.p_s[1:0], supply_ok_i};
		if (q.w_s[1] == q.w_s[2]) begin
			next_q.w = q.w_s[2];
		end
		if (q.t_s[1] == q.t_s[2]) begin
			next_q.t = q.t_s[2];
		end
		if (q.p_s[1] == q.p_s[2]) begin
			next_q.p = q.p_s[2];
		end
		if (tick && q.tmr != 20'hFFFFF) begin
			next_q.tmr = q.tmr + 20'h00001;
		end
		next_q.cap_rd = cap_event_i && q.conn;
		unique case (q.st)
			S_IDLE: begin
				if (!q.w) begin
					next_q.st = S_SUPPLY;
					restart = 1'b1;
				end
			end
			S_SUPPLY: begin
				if (q.tmr >= C_SUP_MIN && q.p) begin
					next_q.st = S_WAKE;
					next_q.phase = 3'h0;
					restart = 1'b1;
				end else if (q.tmr >= C_SUP_MAX) begin
					next_q.st = S_CONTEND;
				end
			end
			S_WAKE: begin
				if (q.tmr >= ((q.phase == 3'h3) ? C_WAKE_L : C_WAKE_S)) begin
					restart = 1'b1;
					next_q.phase = q.phase + 3'h1;
					if (q.phase == 3'(WAKE_PHASES - 1)) begin
						next_q.st = S_W2D;
					end
				end
			end
			S_W2D: begin
				if (q.tmr >= C_W2D) begin
					next_q.st = S_DISC_HI;
					next_q.pulses = 5'h00;
					restart = 1'b1;
				end
			end
			S_DISC_HI: begin
				if (q.tmr >= C_PULSE) begin
					next_q.st = S_DISC_FL;
					restart = 1'b1;
				end
			end
			S_DISC_FL: begin
				if (q.w && q.tmr >= C_GUARD) begin
					next_q.st = S_CONN;
					next_q.term_seen = 1'b0;
					next_q.dg = 20'h00000;
					restart = 1'b1;
				end else if (q.tmr >= C_PULSE) begin
					restart = 1'b1;
					next_q.pulses = q.pulses + 5'h01;
					next_q.st = (q.pulses == 5'(SRC_PULSE_LIMIT - 1)) ?
						S_NO_SINK : S_DISC_HI;
				end
			end
			S_CONN: begin
				if (q.tmr >= C_ARB || peer_arb_i) begin
					next_q.arb_ok = 1'b1;
				end
				if (q.t) begin
					next_q.term_seen = 1'b1;
					next_q.dg = 20'h00000;
				end else if (q.term_seen && tick) begin
					next_q.dg = q.dg + 20'h00001;
				end
				if ((q.term_seen && q.dg >= C_DEGLITCH) ||
					(!q.term_seen && q.tmr >= C_TERM_CHK)) begin
					next_q.st = S_FLOAT;
					restart = 1'b1;
				end
			end
			S_FLOAT: begin
				if (q.tmr >= C_FLOAT) begin
					next_q.st = S_IDLE;
					restart = 1'b1;
				end
			end
			S_NO_SINK, S_CONTEND: begin
			end
			default: next_q.st = S_IDLE;
		endcase
		if (disconnect_i && q.st != S_FLOAT && q.st != S_IDLE) begin
			next_q.st = S_FLOAT;
			restart = 1'b1;
		end
		if (restart) begin
			next_q.tmr = 20'h00000;
		end
		next_q.conn = (next_q.st == S_CONN);
		next_q.oe_n = !(next_q.st == S_WAKE || next_q.st == S_DISC_HI);
		next_q.drv = (next_q.st == S_DISC_HI) ||
			(next_q.st == S_WAKE && !next_q.phase[0]);
		next_q.pu_disc = next_q.st inside {S_IDLE, S_SUPPLY, S_W2D, S_DISC_FL};
		next_q.pu_on = next_q.conn;
		next_q.video_en = next_q.conn && next_q.term_seen;
		next_q.arb_ok = next_q.conn && next_q.arb_ok;
		next_q.no_sink = (next_q.st == S_NO_SINK);
		next_q.contend = (next_q.st == S_CONTEND);
	end

	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			q <= Q_RST;
		end else begin
			q <= next_q;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign bus.src_drv = q.drv;
	assign bus.src_oe_n = q.oe_n;
	assign bus.src_pu_disc = q.pu_disc;
	assign bus.src_pu_on = q.pu_on;
	assign connected_o = q.conn;
	assign video_en_o = q.video_en;
	assign arb_ok_o = q.arb_ok;
	assign cap_read_o = q.cap_rd;
	assign no_sink_o = q.no_sink;
	assign contention_o = q.contend;
endmodule

`default_nettype wire

// ### rtl/wire_link_pkg.sv
/*
 * Shared constants for the control-wire connection logic.
 * Assumes a single 40 MHz system clock on both ends.
 */
package wire_link_pkg;

	// ****************************************
	// Clock and tick
	// ****************************************
	localparam int CLK_PERIOD_PS = 25000;
	localparam int US_PS         = 1000000;
	localparam int CYC_PER_US    = US_PS / CLK_PERIOD_PS;
	localparam int US_PER_MS     = 1000;

	// ****************************************
	// Source timing, milliseconds
	// ****************************************
	localparam int WAKE_SHORT_MS    = 20;
	localparam int WAKE_LONG_MS     = 60;
	localparam int WAKE_TO_DISC_MS  = 100;
	localparam int SUPPLY_MIN_MS    = 100;
	localparam int SUPPLY_MAX_MS    = 1000;
	localparam int SRC_FLOAT_MS     = 50;
	localparam int DEGLITCH_MS      = 150;
	localparam int TERM_CHECK_MS    = 400;

	// ****************************************
	// Microsecond timing and counts
	// ****************************************
	localparam int PULSE_US         = 100;
	localparam int FLOAT_GUARD_US   = 2;
	localparam int ARB_HOLD_US      = 500;
	localparam int ACCEPT_MIN_US    = 70;
	localparam int ACCEPT_MAX_US    = 130;
	localparam int SINK_LOW_DISC_US = 200;
	localparam int WAKE_PHASES      = 7;
	localparam int SRC_PULSE_LIMIT  = 20;
	localparam int SINK_PULSE_COUNT = 5;

endpackage

// ### rtl/control_wire_if.sv
/*
 * Control-wire carrier between source and sink ends.
 * Resolves the single wire level from the driver, pull-ups and the discovery pull-down.
 */
`timescale 1ns/100ps
`default_nettype none

interface control_wire_if;
	logic src_drv;
	logic src_oe_n;
	logic src_pu_disc;
	logic src_pu_on;
	logic snk_pd_disc;
	logic snk_pd_on;
	logic snk_term_en;
	logic control_wire;
	logic receiver_termination_sense;

	// Strong discovery pull-down beats either source pull-up
	assign control_wire = !src_oe_n ? src_drv :
		((src_pu_disc | src_pu_on) & !snk_pd_disc);
	assign receiver_termination_sense = snk_term_en;

	modport source (
		output src_drv, src_oe_n, src_pu_disc, src_pu_on,
		input  control_wire, receiver_termination_sense
	);
	modport sink (
		output snk_pd_disc, snk_pd_on, snk_term_en,
		input  control_wire
	);
endinterface

`default_nettype wire

// ### rtl/tick_divider.sv
/*
 * Divides the system clock into a one-cycle enable pulse.
 * Assumes DIV fits eight bits.
 */
`timescale 1ns/100ps
`default_nettype none

module tick_divider #(
	parameter int DIV = 40
) (
	input  wire logic clk_sys_i,
	input  wire logic srst_i,
	output logic      tick_o
);
	typedef struct packed {
		logic [7:0] cnt;
		logic       tick;
	} div_q_s;

	div_q_s q;
	div_q_s next_q;

	always_comb begin
		next_q = q;
		next_q.tick = (q.cnt == 8'(DIV - 1));
		next_q.cnt = next_q.tick ? 8'h00 : q.cnt + 8'h01;
	end

	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			q <= '0;
		end else begin
			q <= next_q;
		end
	end

	assign tick_o = q.tick;
endmodule

`default_nettype wire

// ### rtl/sink_link_end.sv
/*
 * Sink end of the control wire: discovery pulse counting, connect,
 * low-time disconnect, termination and capability notifications.
 * Assumes same-clock inputs from the link layer; wire is asynchronous.
 */
`timescale 1ns/100ps
`default_nettype none

module sink_link_end
	import wire_link_pkg::*;
(
	input  wire logic       clk_sys_i,
	input  wire logic       srst_i,
	control_wire_if.sink    bus,
	input  wire logic       ready_i,
	input  wire logic       peer_arb_i,
	input  wire logic       power_on_i,
	output logic            connected_o,
	output logic            arb_ok_o,
	output logic            capability_ready_flag_o,
	output logic            capability_changed_interrupt_o
);
	// ****************************************
	// State
	// ****************************************
	typedef enum logic [3:0] {
		K_FLOAT = 4'h1,
		K_DISC  = 4'h2,
		K_CONNA = 4'h4,
		K_CONNB = 4'h8
	} sink_state_e;

	typedef struct packed {
		sink_state_e st;
		logic [2:0]  w_s;
		logic        w;
		logic [7:0]  wid;
		logic        hi_ok;
		logic [2:0]  cnt;
		logic [8:0]  hold;
		logic        pd_disc;
		logic        pd_on;
		logic        term_en;
		logic        cap_rdy;
		logic        cap_chg;
		logic        arb_ok;
		logic        conn;
	} sink_q_s;

	localparam sink_q_s Q_RST = '{st: K_FLOAT, default: '0};

	sink_q_s q;
	sink_q_s next_q;
	logic    tick;
	logic    valid;

	tick_divider #(.DIV(CYC_PER_US)) u_div (
		.clk_sys_i (clk_sys_i),
		.srst_i    (srst_i),
		.tick_o    (tick)
	);

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		next_q = q;
		next_q.w_s = {q.w_s[1:0], bus.control_wire};
		if (q.w_s[1] == q.w_s[2]) begin
			next_q.w = q.w_s[2];
		end
		// Tick phase can cost one count at the lower bound
		valid = (q.wid >= 8'(ACCEPT_MIN_US - 1)) && (q.wid <= 8'(ACCEPT_MAX_US));
		next_q.cap_chg = power_on_i && q.conn;
		if (next_q.w != q.w) begin
			next_q.wid = 8'h00;
		end else if (tick && q.wid != 8'hFF) begin
			next_q.wid = q.wid + 8'h01;
		end
		if (tick && q.hold != 9'h1FF) begin
			next_q.hold = q.hold + 9'h001;
		end
		unique case (q.st)
			K_FLOAT: begin
				if (ready_i) begin
					next_q.st = K_DISC;
					next_q.cnt = 3'h0;
					next_q.hi_ok = 1'b0;
				end
			end
			K_DISC: begin
				if (next_q.w != q.w) begin
					if (q.w) begin
						next_q.hi_ok = valid;
					end else begin
						next_q.hi_ok = 1'b0;
						if (q.hi_ok && valid) begin
							next_q.cnt = q.cnt + 3'h1;
							if (q.cnt == 3'(SINK_PULSE_COUNT - 1)) begin
								next_q.st = K_CONNA;
								next_q.hold = 9'h000;
							end
						end
					end
				end
			end
			K_CONNA, K_CONNB: begin
				if (q.st == K_CONNA &&
					(peer_arb_i || q.hold >= 9'(ARB_HOLD_US))) begin
					next_q.st = K_CONNB;
				end
				if (!q.w && q.wid >= 8'(SINK_LOW_DISC_US)) begin
					next_q.st = K_DISC;
					next_q.cnt = 3'h0;
					next_q.hi_ok = 1'b0;
				end
			end
			default: next_q.st = K_FLOAT;
		endcase
		if (!ready_i) begin
			next_q.st = K_FLOAT;
		end
		next_q.conn = next_q.st inside {K_CONNA, K_CONNB};
		next_q.pd_disc = (next_q.st == K_DISC);
		next_q.pd_on = next_q.conn;
		next_q.term_en = next_q.conn;
		next_q.cap_rdy = next_q.conn;
		next_q.arb_ok = (next_q.st == K_CONNB);
	end

	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			q <= Q_RST;
		end else begin
			q <= next_q;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign bus.snk_pd_disc = q.pd_disc;
	assign bus.snk_pd_on = q.pd_on;
	assign bus.snk_term_en = q.term_en;
	assign connected_o = q.conn;
	assign arb_ok_o = q.arb_ok;
	assign capability_ready_flag_o = q.cap_rdy;
	assign capability_changed_interrupt_o = q.cap_chg;
endmodule

`default_nettype wire

// ### testbench/control_wire_properties.sv
/*
 * Timing checks on the control wire between source and sink ends.
 * Assumes one system clock and the signals of the wire carrier.
 */
`timescale 1ns/100ps
`default_nettype none

module control_wire_properties
	import wire_link_pkg::*;
#(
	parameter int US_PER_MS_P = US_PER_MS
) (
	input wire logic clk_sys_i,
	input wire logic srst_i,
	input wire logic src_drv,
	input wire logic src_oe_n,
	input wire logic src_pu_disc,
	input wire logic src_pu_on,
	input wire logic snk_pd_disc,
	input wire logic snk_pd_on,
	input wire logic snk_term_en,
	input wire logic control_wire
);
	localparam int C  = CYC_PER_US;
	localparam int MS = US_PER_MS_P * C;
	logic drv_hi;
	logic drv_lo;
	logic left_conn;
	int   hi_n;
	int   lo_n;
	int   fl_n;
	int   off_n;
	int   rise_n;
	int   wlo_n;

	// ********
	// Phase counters
	// ********
	assign drv_hi = !src_oe_n && src_drv;
	assign drv_lo = !src_oe_n && !src_drv;

	always_ff @(posedge clk_sys_i) begin
		hi_n <= (drv_hi && !srst_i) ? hi_n + 1 : 0;
		lo_n <= (drv_lo && !srst_i) ? lo_n + 1 : 0;
		fl_n <= (src_oe_n && src_pu_disc && !control_wire && !srst_i) ? fl_n + 1 : 0;
		off_n <= (src_oe_n && !src_pu_disc && !src_pu_on && !srst_i) ? off_n + 1 : 0;
		wlo_n <= (!control_wire && !srst_i) ? wlo_n + 1 : 0;
		rise_n <= (srst_i || $rose(control_wire)) ? 0 : rise_n + 1;
		left_conn <= !srst_i && !src_pu_disc && (left_conn || $fell(src_pu_on));
	end

	// ********
	// Wire timing
	// ********
	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (srst_i);

	a_high_width: assert property (
		$fell(drv_hi) |-> (hi_n >= 79 * C && hi_n <= 120 * C) ||
			(hi_n >= 18 * MS - C && hi_n <= 22 * MS))
		else $error("driven high phase width wrong");
	a_low_width: assert property (
		$fell(drv_lo) |-> (lo_n >= 18 * MS - C && lo_n <= 22 * MS) ||
			(lo_n >= 54 * MS - C && lo_n <= 66 * MS))
		else $error("driven low phase width wrong");
	a_float_width: assert property (
		$fell(src_oe_n) |-> (fl_n >= 79 * C && fl_n <= 120 * C) ||
			(fl_n >= 100 * MS - C && fl_n <= 1000 * MS + C))
		else $error("float phase before drive wrong");
	a_source_connect: assert property (
		$rose(src_oe_n) && src_pu_disc && control_wire |-> ##[1:1000] src_pu_on)
		else $error("source pull-up late");
	a_release_float: assert property (
		$rose(src_pu_disc) && left_conn |-> off_n >= 50 * MS - C)
		else $error("disconnect float too short");
	a_release_wire: assert property (
		$fell(src_pu_on) |-> src_oe_n && !src_pu_disc)
		else $error("wire not released on disconnect");
	a_sink_connect: assert property (
		$fell(snk_pd_disc) |-> snk_pd_on && rise_n <= 40 * C)
		else $error("sink connect late");
	a_sink_term: assert property (
		$rose(snk_pd_on) |-> ##[0:1000] snk_term_en)
		else $error("sink termination late");
	a_low_min: assert property (
		$fell(snk_pd_on) |-> wlo_n >= 150 * C)
		else $error("sink disconnect too early");
	a_low_max: assert property (
		snk_pd_on |-> wlo_n <= 240 * C)
		else $error("sink disconnect too late");
	a_sink_restore: assert property (
		$rose(snk_pd_disc) |-> !snk_pd_on && !snk_term_en)
		else $error("sink restore incomplete");
endmodule

`default_nettype wire

// ### testbench/control_wire_wake_discovery_connect_test.sv
/*
 * Bench for both link ends joined by the carrier, plus a second sink
 * driven by hand. Assumes a 40 MHz clock and shortened ms intervals.
 */
`timescale 1ns/100ps
`default_nettype none

module control_wire_wake_discovery_connect_test;
	import wire_link_pkg::*;
	localparam int P = 5;
	logic clk_sys_i = 1'h0;
	logic srst_i    = 1'h1;
	logic supply_ok = 1'h0;
	logic s_peer    = 1'h0;
	logic cap_ev    = 1'h0;
	logic disc      = 1'h0;
	logic ready     = 1'h1;
	logic pwr       = 1'h0;
	logic k2_peer   = 1'h0;
	logic pwr2      = 1'h0;
	logic ready2    = 1'h1;
	logic s_conn, s_vid, s_arb, s_cap, s_nos, s_cont;
	logic k_conn, k_arb, k_rdy, k_chg, k2_conn, k2_arb;
	int   err_total = 0;
	int   compares  = 0;
	int   w;

	control_wire_if link ();
	control_wire_if link2 ();

	source_link_end #(.US_PER_MS_P(P)) u_source_link_end (
		.clk_sys_i, .srst_i, .bus(link.source), .supply_ok_i(supply_ok),
		.peer_arb_i(s_peer), .cap_event_i(cap_ev), .disconnect_i(disc),
		.connected_o(s_conn), .video_en_o(s_vid), .arb_ok_o(s_arb),
		.cap_read_o(s_cap), .no_sink_o(s_nos), .contention_o(s_cont)
	);
	sink_link_end u_sink_link_end (
		.clk_sys_i, .srst_i, .bus(link.sink), .ready_i(ready),
		.peer_arb_i(s_peer), .power_on_i(pwr), .connected_o(k_conn),
		.arb_ok_o(k_arb), .capability_ready_flag_o(k_rdy),
		.capability_changed_interrupt_o(k_chg)
	);
	sink_link_end u_sink_link_end_2 (
		.clk_sys_i, .srst_i, .bus(link2.sink), .ready_i(ready2),
		.peer_arb_i(k2_peer), .power_on_i(pwr2), .connected_o(k2_conn),
		.arb_ok_o(k2_arb), .capability_ready_flag_o(),
		.capability_changed_interrupt_o()
	);
	control_wire_properties #(.US_PER_MS_P(P)) u_props (
		.clk_sys_i, .srst_i, .src_drv(link.src_drv), .src_oe_n(link.src_oe_n),
		.src_pu_disc(link.src_pu_disc), .src_pu_on(link.src_pu_on),
		.snk_pd_disc(link.snk_pd_disc), .snk_pd_on(link.snk_pd_on),
		.snk_term_en(link.snk_term_en), .control_wire(link.control_wire)
	);

	always #12.5 clk_sys_i = ~clk_sys_i;

	// ********
	// Helpers
	// ********
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			err_total++;
			$display("unexpected %s expected %0h seen %0h", name, exp, seen);
		end
	endtask

	task automatic us(input int n);
		repeat (n * CYC_PER_US) @(negedge clk_sys_i);
	endtask

	task automatic complete_run;
		$display("errors %0d compares %0d", err_total, compares);
		if (err_total == 0 && compares > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// ********
	// Hand-made pulses into the second sink
	// ********
	task automatic far_pulses;
		int i;
		int r;
		us(10);
		for (i = 0; i < 6; i++) begin
			// Acceptance corners first, then random widths
			w = (i == 0) ? 70 : (i == 1) ? 130 : $urandom_range(125, 72);
			link2.src_drv = 1'h1;
			us(3);
			check("sink_connected_state_a connected", k2_conn, i == 5);
			if (i < 5) begin
				us(w - 3);
				link2.src_drv = 1'h0;
				us(w);
			end
			if (i == 3) begin
				r = $urandom_range(1) ? $urandom_range(40, 20) : $urandom_range(240, 201);
				link2.src_drv = 1'h1;
				us(r);
				link2.src_drv = 1'h0;
				us(r);
			end
		end
		check("sink_connected_state_a arb", k2_arb, 0);
		k2_peer = 1'h1;
		us(1);
		k2_peer = 1'h0;
		check("sink_connected_state_a arb", k2_arb, 1);
		link2.src_drv = 1'h0;
		us($urandom_range(140, 100));
		link2.src_drv = 1'h1;
		us(5);
		check("sink_connected_state_a connected", k2_conn, 1);
		link2.src_drv = 1'h0;
		us(245);
		check("sink_connected_state_a connected", k2_conn, 0);
		check("sink_connected_state_a pulldown", link2.snk_pd_disc, 1);
		check("sink_connected_state_a termination", link2.snk_term_en, 0);
		ready2 = 1'h0;
		us(1);
		check("sink_connected_state_a pulldown", link2.snk_pd_disc, 0);
		ready2 = 1'h1;
		us(1);
		check("sink_connected_state_a pulldown", link2.snk_pd_disc, 1);
		check("sink_connected_state_a connected", k2_conn, 0);
	endtask

	// ********
	// Full connect and disconnect of the joined pair
	// ********
	task automatic near_flow;
		int t;
		int n1;
		int n2;
		us($urandom_range(400, 100));
		supply_ok = 1'h1;
		t = 0;
		while (s_conn !== 1'h1 && t < 4000) begin
			us(1);
			t++;
		end
		check("source connected", s_conn, 1);
		check("sink connected", k_conn, 1);
		check("no sink", s_nos, 0);
		check("contention", s_cont, 0);
		us(300);
		check("sink arb", k_arb, 0);
		check("source arb", s_arb, 0);
		us(180);
		check("sink arb", k_arb, 1);
		check("source arb", s_arb, 0);
		us(30);
		check("source arb", s_arb, 1);
		check("video", s_vid, 1);
		check("cap ready", k_rdy, 1);
		cap_ev = 1'h1;
		pwr = 1'h1;
		@(negedge clk_sys_i);
		n1 = (s_cap === 1'h1);
		n2 = (k_chg === 1'h1);
		cap_ev = 1'h0;
		pwr = 1'h0;
		repeat (3) begin
			@(negedge clk_sys_i);
			n1 += (s_cap === 1'h1);
			n2 += (k_chg === 1'h1);
		end
		check("cap read", n1, 1);
		check("cap changed", n2, 1);
		disc = 1'h1;
		us(1);
		disc = 1'h0;
		check("source connected", s_conn, 0);
		check("video", s_vid, 0);
		us(139);
		check("sink connected", k_conn, 1);
		check("source pullup", link.src_pu_disc, 0);
		us(105);
		check("sink connected", k_conn, 0);
		check("source pullup", link.src_pu_disc, 0);
		check("sink termination", link.snk_term_en, 0);
		us(15);
		check("source pullup", link.src_pu_disc, 1);
	endtask

	initial begin
		link2.src_drv = 1'h0;
		link2.src_oe_n = 1'h0;
		link2.src_pu_disc = 1'h0;
		link2.src_pu_on = 1'h0;
		w = $urandom(32'h78B5);
		repeat (5) @(negedge clk_sys_i);
		srst_i = 1'h0;
		check("source connected", s_conn, 0);
		fork
			far_pulses();
			near_flow();
		join
		complete_run();
	end

	initial begin
		repeat (200000) @(posedge clk_sys_i);
		err_total++;
		complete_run();
	end
endmodule

`default_nettype wire
